/* File: hw/ifb_pkg.sv */
// Package: register map, field positions and reset values of the request flag bank
package ifb_pkg;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef logic [7:0] ifb_addr_t;
	typedef logic [31:0] ifb_word_t;
	typedef logic [15:0] ifb_half_t;
	typedef logic [3:0] ifb_be_t;
	typedef logic [2:0] ifb_prio_t;
	typedef logic [2:0] ifb_grp_t;

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam ifb_addr_t OFF_FLAGS_0 = 8'h00;
	localparam ifb_addr_t OFF_FLAGS_1 = 8'h04;
	localparam ifb_addr_t OFF_FLAGS_4 = 8'h08;
	localparam ifb_addr_t OFF_ENABLES_0 = 8'h0c;
	localparam ifb_addr_t OFF_ENABLES_1 = 8'h10;
	localparam ifb_addr_t OFF_ENABLES_4 = 8'h14;
	localparam ifb_addr_t OFF_POLARITY = 8'h18;
	localparam ifb_addr_t OFF_IRQ_STATUS = 8'h30;
	localparam ifb_addr_t OFF_IRQ_MASK = 8'h34;
	localparam ifb_addr_t OFF_PRIO_BASE = 8'h40;
	localparam ifb_addr_t PRIO_GROUP_STRIDE = 8'h10;

	// ****************************************************************
	// Flag / enable bit positions (same in both banks)
	// ****************************************************************
	localparam int POS_ADC_DONE = 13;
	localparam int POS_SERIAL_TX = 12;
	localparam int POS_SERIAL_RX = 11;
	localparam int POS_SPI_EVENT = 10;
	localparam int POS_SPI_FAULT = 9;
	localparam int POS_TIMER_THREE = 8;
	localparam int POS_TIMER_TWO = 7;
	localparam int POS_COMPARE_TWO = 6;
	localparam int POS_CAPTURE_TWO = 5;
	localparam int POS_TIMER_ONE = 3;
	localparam int POS_COMPARE_ONE = 2;
	localparam int POS_CAPTURE_ONE = 1;
	localparam int POS_EXT_PIN_ZERO = 0;
	localparam int POS_EXT_PIN_TWO = 13;
	localparam int POS_CAPTURE_EIGHT = 7;
	localparam int POS_CAPTURE_SEVEN = 6;
	localparam int POS_EXT_PIN_ONE = 4;
	localparam int POS_PIN_CHANGE = 3;
	localparam int POS_I2C_MASTER = 1;
	localparam int POS_I2C_SLAVE = 0;
	localparam int POS_SERIAL_ERROR = 1;

	// Implemented bits of each bank
	localparam ifb_half_t IMPL_0 = ifb_half_t'((1 << POS_ADC_DONE) | (1 << POS_SERIAL_TX)
		| (1 << POS_SERIAL_RX) | (1 << POS_SPI_EVENT) | (1 << POS_SPI_FAULT)
		| (1 << POS_TIMER_THREE) | (1 << POS_TIMER_TWO) | (1 << POS_COMPARE_TWO)
		| (1 << POS_CAPTURE_TWO) | (1 << POS_TIMER_ONE) | (1 << POS_COMPARE_ONE)
		| (1 << POS_CAPTURE_ONE) | (1 << POS_EXT_PIN_ZERO));
	localparam ifb_half_t IMPL_1 = ifb_half_t'((1 << POS_EXT_PIN_TWO)
		| (1 << POS_CAPTURE_EIGHT) | (1 << POS_CAPTURE_SEVEN) | (1 << POS_EXT_PIN_ONE)
		| (1 << POS_PIN_CHANGE) | (1 << POS_I2C_MASTER) | (1 << POS_I2C_SLAVE));
	localparam ifb_half_t IMPL_4 = ifb_half_t'(1 << POS_SERIAL_ERROR);

	// Priority field layout: four 3-bit fields per register, one per nibble
	localparam int PRIO_FIELD_STRIDE = 4;
	localparam int PRIO_FIELDS_PER_REG = 4;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam ifb_half_t FLAG_RESET = 16'h0000;
	localparam ifb_half_t ENABLE_RESET = 16'h0000;
	localparam ifb_grp_t POLARITY_RESET = 3'h0;
	localparam ifb_grp_t IRQ_STATUS_RESET = 3'h0;
	localparam ifb_grp_t IRQ_MASK_RESET = 3'h0;
	localparam ifb_prio_t PRIO_RESET = 3'h4;
	localparam ifb_prio_t PRIO_DISABLED = 3'h0;

endpackage

/* File: hw/ifb_flag_if.sv */
// Interface: write port, event inputs and stored flags of one request flag bank
interface ifb_flag_if;
	logic wr_en;
	logic [15:0] wr_data;
	logic [15:0] set;
	logic [15:0] flags;

	modport bank(input wr_en, input wr_data, input set, output flags);
	modport ctrl(output wr_en, output wr_data, output set, input flags);
endinterface

/* File: hw/ifb_flag_bank.sv */
// Module: one 16-bit sticky request flag register with event set and software write
module ifb_flag_bank #(
	parameter logic [15:0] IMPL = 16'hffff
) (
	input wire logic clk_in,
	input wire logic rst_in,
	ifb_flag_if.bank bank
);
	import ifb_pkg::*;

	// ****************************************************************
	// Flag storage
	// ****************************************************************
	// Event ORed after the write so a clear never swallows a same-cycle event
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			bank.flags <= FLAG_RESET;
		end else if (bank.wr_en) begin
			bank.flags <= (bank.wr_data | bank.set) & IMPL;
		end else begin
			bank.flags <= (bank.flags | bank.set) & IMPL;
		end
	end
endmodule

/* File: hw/ifb_pin_edge.sv */
// Module: edge detectors for the three external interrupt pins
module ifb_pin_edge (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [2:0] pin_in,
	input wire logic [2:0] polarity_in,
	output logic [2:0] edge_out
);
	import ifb_pkg::*;

	logic [2:0] pin_prev;

	// ****************************************************************
	// Previous pin levels
	// ****************************************************************
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pin_prev <= 3'h0;
		end else begin
			pin_prev <= pin_in;
		end
	end

	// Polarity one picks the falling edge, zero the rising edge
	for (genvar i = 0; i < 3; i++) begin : g_pin
		assign edge_out[i] = polarity_in[i] ? (pin_prev[i] & ~pin_in[i])
			: (~pin_prev[i] & pin_in[i]);
	end
endmodule

/* File: hw/ifb_top.sv */
// Top: interrupt request flag and enable bank with an Avalon-MM register slave
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
module ifb_top (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire ifb_pkg::ifb_addr_t AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire ifb_pkg::ifb_word_t AVS_WRITEDATA_IN,
	input wire ifb_pkg::ifb_be_t AVS_BYTEENABLE_IN,
	output ifb_pkg::ifb_word_t AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	input wire ifb_pkg::ifb_half_t EVENT0_IN,
	input wire ifb_pkg::ifb_half_t EVENT1_IN,
	input wire ifb_pkg::ifb_half_t EVENT4_IN,
	input wire logic [2:0] EXT_PIN_IN,
	output ifb_pkg::ifb_half_t REQUEST0_OUT,
	output ifb_pkg::ifb_half_t REQUEST1_OUT,
	output ifb_pkg::ifb_half_t REQUEST4_OUT,
	output ifb_pkg::ifb_prio_t PRIO_LEVEL_OUT,
	output logic IRQ_OUT
);
	import ifb_pkg::*;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Byte-lane merge of a 16-bit register with bus write data
	function automatic ifb_half_t merge(input ifb_half_t old_val, input ifb_word_t wd,
		input ifb_be_t be);
		ifb_half_t res;
		res[7:0] = be[0] ? wd[7:0] : old_val[7:0];
		res[15:8] = be[1] ? wd[15:8] : old_val[15:8];
		return res;
	endfunction

	// Implemented-bit mask of a group
	function automatic ifb_half_t impl_of(input int g);
		ifb_half_t m;
		case (g)
			0: m = IMPL_0;
			1: m = IMPL_1;
			default: m = IMPL_4;
		endcase
		return m;
	endfunction

	// Byte offset of a priority register for group g, field block k
	function automatic ifb_addr_t prio_off(input int g, input int k);
		return OFF_PRIO_BASE + ifb_addr_t'(g) * PRIO_GROUP_STRIDE + ifb_addr_t'(k * 4);
	endfunction

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic waitrequest;
	logic accept_wr;
	logic accept_rd;
	ifb_half_t enables [3];
	ifb_prio_t prio [3][16];
	ifb_grp_t polarity;
	ifb_grp_t irq_status;
	ifb_grp_t irq_mask;
	ifb_grp_t new_request;
	logic [2:0] pin_edge;
	ifb_half_t flag_off [3];
	ifb_half_t ev_in [3];
	ifb_half_t flags [3];
	ifb_half_t qual [3];
	ifb_half_t request [3];
	ifb_half_t prio_rd [3][4];
	ifb_half_t prio_wr [3][4];
	ifb_half_t rd_value;
	ifb_prio_t next_level;

	ifb_flag_if bank_if [3] ();

	assign flag_off[0] = OFF_FLAGS_0;
	assign flag_off[1] = OFF_FLAGS_1;
	assign flag_off[2] = OFF_FLAGS_4;

	// Pin edges replace the raw event lines at the pin flag positions
	assign ev_in[0] = (EVENT0_IN & ~ifb_half_t'(1 << POS_EXT_PIN_ZERO))
		| (ifb_half_t'(pin_edge[0]) << POS_EXT_PIN_ZERO);
	assign ev_in[1] = (EVENT1_IN
		& ~ifb_half_t'((1 << POS_EXT_PIN_ONE) | (1 << POS_EXT_PIN_TWO)))
		| (ifb_half_t'(pin_edge[1]) << POS_EXT_PIN_ONE)
		| (ifb_half_t'(pin_edge[2]) << POS_EXT_PIN_TWO);
	assign ev_in[2] = EVENT4_IN;

	// Bus handshake: the accepting edge is the one where waitrequest is low
	assign accept_wr = AVS_WRITE_IN && !waitrequest;
	assign accept_rd = AVS_READ_IN && !waitrequest;

	// ****************************************************************
	// Pin edge detection
	// ****************************************************************
	ifb_pin_edge u_pin_edge (
		.clk_in(CLOCK_IN),
		.rst_in(RST_IN),
		.pin_in(EXT_PIN_IN),
		.polarity_in(polarity),
		.edge_out(pin_edge)
	);

	// ****************************************************************
	// Flag banks
	// ****************************************************************
	for (genvar g = 0; g < 3; g++) begin : g_bank
		// Implemented positions of this bank, held as a constant for bit selects
		localparam ifb_half_t impl_g = impl_of(g);

		// Write strobe and merged data; absent bits are dropped in the bank
		assign bank_if[g].wr_en = accept_wr && (AVS_ADDRESS_IN == flag_off[g]);
		assign bank_if[g].wr_data = merge(bank_if[g].flags, AVS_WRITEDATA_IN,
			AVS_BYTEENABLE_IN);
		assign bank_if[g].set = ev_in[g] & impl_of(g);
		assign flags[g] = bank_if[g].flags;

		ifb_flag_bank #(
			.IMPL(impl_of(g))
		) u_bank (
			.clk_in(CLOCK_IN),
			.rst_in(RST_IN),
			.bank(bank_if[g])
		);

		// A request goes out only with flag, enable and a nonzero priority
		always_comb begin
			for (int b = 0; b < 16; b++) begin
				qual[g][b] = flags[g][b] && enables[g][b]
					&& (prio[g][b] != PRIO_DISABLED);
			end
		end

		// Priority register read images, absent fields read as zero
		for (genvar k = 0; k < PRIO_FIELDS_PER_REG; k++) begin : g_prd
			always_comb begin
				prio_rd[g][k] = 16'h0000;
				for (int j = 0; j < PRIO_FIELDS_PER_REG; j++) begin
					if (impl_g[k * 4 + j]) begin
						prio_rd[g][k][j * PRIO_FIELD_STRIDE +: 3] = prio[g][k * 4 + j];
					end
				end
				// Write image: bus bytes merged over the current read image
				prio_wr[g][k] = merge(prio_rd[g][k], AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
			end
		end
	end

	// ****************************************************************
	// Enable registers
	// ****************************************************************
	// Software write only; absent positions stay zero
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			for (int g = 0; g < 3; g++) begin
				enables[g] <= ENABLE_RESET;
			end
		end else if (accept_wr) begin
			case (AVS_ADDRESS_IN)
				OFF_ENABLES_0: enables[0] <= merge(enables[0], AVS_WRITEDATA_IN,
					AVS_BYTEENABLE_IN) & IMPL_0;
				OFF_ENABLES_1: enables[1] <= merge(enables[1], AVS_WRITEDATA_IN,
					AVS_BYTEENABLE_IN) & IMPL_1;
				OFF_ENABLES_4: enables[2] <= merge(enables[2], AVS_WRITEDATA_IN,
					AVS_BYTEENABLE_IN) & IMPL_4;
				default: enables[0] <= enables[0];
			endcase
		end
	end

	// ****************************************************************
	// Priority fields
	// ****************************************************************
	// Reset to the middle level so enabled sources work without setup
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			for (int g = 0; g < 3; g++) begin
				for (int b = 0; b < 16; b++) begin
					prio[g][b] <= PRIO_RESET;
				end
			end
		end else if (accept_wr) begin
			for (int g = 0; g < 3; g++) begin
				for (int k = 0; k < PRIO_FIELDS_PER_REG; k++) begin
					if (AVS_ADDRESS_IN == prio_off(g, k)) begin
						for (int j = 0; j < PRIO_FIELDS_PER_REG; j++) begin
							prio[g][k * 4 + j] <= prio_wr[g][k][j * PRIO_FIELD_STRIDE +: 3];
						end
					end
				end
			end
		end
	end

	// ****************************************************************
	// Pin polarity
	// ****************************************************************
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			polarity <= POLARITY_RESET;
		end else if (accept_wr && AVS_ADDRESS_IN == OFF_POLARITY && AVS_BYTEENABLE_IN[0]) begin
			polarity <= AVS_WRITEDATA_IN[2:0];
		end
	end

	// ****************************************************************
	// Request outputs and priority level
	// ****************************************************************
	// Rising request detection feeds the summary status
	always_comb begin
		for (int g = 0; g < 3; g++) begin
			new_request[g] = |(qual[g] & ~request[g]);
		end
	end

	// Highest priority among requests now passed on
	always_comb begin
		next_level = PRIO_DISABLED;
		for (int g = 0; g < 3; g++) begin
			for (int b = 0; b < 16; b++) begin
				if (qual[g][b] && prio[g][b] > next_level) begin
					next_level = prio[g][b];
				end
			end
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			for (int g = 0; g < 3; g++) begin
				request[g] <= 16'h0000;
			end
			PRIO_LEVEL_OUT <= PRIO_DISABLED;
		end else begin
			for (int g = 0; g < 3; g++) begin
				request[g] <= qual[g];
			end
			PRIO_LEVEL_OUT <= next_level;
		end
	end

	assign REQUEST0_OUT = request[0];
	assign REQUEST1_OUT = request[1];
	assign REQUEST4_OUT = request[2];

	// ****************************************************************
	// Summary interrupt
	// ****************************************************************
	// Read clears; a new request in the same cycle still sets its bit
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			irq_status <= IRQ_STATUS_RESET;
		end else if (accept_rd && AVS_ADDRESS_IN == OFF_IRQ_STATUS) begin
			irq_status <= new_request;
		end else begin
			irq_status <= irq_status | new_request;
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			irq_mask <= IRQ_MASK_RESET;
		end else if (accept_wr && AVS_ADDRESS_IN == OFF_IRQ_MASK && AVS_BYTEENABLE_IN[0]) begin
			irq_mask <= AVS_WRITEDATA_IN[2:0];
		end
	end

	// Registered, so the line follows the status by one cycle
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			IRQ_OUT <= 1'b0;
		end else begin
			IRQ_OUT <= |(irq_status & irq_mask);
		end
	end

	// ****************************************************************
	// Avalon-MM slave
	// ****************************************************************
	// Read image; unmapped addresses and absent bits give zero
	always_comb begin
		rd_value = 16'h0000;
		case (AVS_ADDRESS_IN)
			OFF_FLAGS_0: rd_value = flags[0];
			OFF_FLAGS_1: rd_value = flags[1];
			OFF_FLAGS_4: rd_value = flags[2];
			OFF_ENABLES_0: rd_value = enables[0];
			OFF_ENABLES_1: rd_value = enables[1];
			OFF_ENABLES_4: rd_value = enables[2];
			OFF_POLARITY: rd_value = {13'h0000, polarity};
			OFF_IRQ_STATUS: rd_value = {13'h0000, irq_status};
			OFF_IRQ_MASK: rd_value = {13'h0000, irq_mask};
			default: begin
				for (int g = 0; g < 3; g++) begin
					for (int k = 0; k < PRIO_FIELDS_PER_REG; k++) begin
						if (AVS_ADDRESS_IN == prio_off(g, k)) begin
							rd_value = prio_rd[g][k];
						end
					end
				end
			end
		endcase
	end

	// One wait cycle per access; waitrequest rests high between accesses
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= !((AVS_READ_IN || AVS_WRITE_IN) && waitrequest);
		end
	end

	// Data captured as the wait drops, so it stands at the accepting edge
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			AVS_READDATA_OUT <= 32'h0000_0000;
		end else if (AVS_READ_IN && waitrequest) begin
			AVS_READDATA_OUT <= {16'h0000, rd_value};
		end
	end

	assign AVS_WAITREQUEST_OUT = waitrequest;
endmodule

/* File: test/ifb_top_props.sv */
// Checker: bus timing, read masks, request causes and reset state of the flag bank
module ifb_top_chk (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire ifb_pkg::ifb_addr_t AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire ifb_pkg::ifb_word_t AVS_READDATA_OUT,
	input wire logic AVS_WAITREQUEST_OUT,
	input wire ifb_pkg::ifb_half_t EVENT0_IN,
	input wire ifb_pkg::ifb_half_t REQUEST0_OUT,
	input wire ifb_pkg::ifb_half_t REQUEST1_OUT,
	input wire ifb_pkg::ifb_half_t REQUEST4_OUT,
	input wire ifb_pkg::ifb_prio_t PRIO_LEVEL_OUT,
	input wire logic IRQ_OUT
);
	import ifb_pkg::*;
	logic acc_wr;
	logic acc_rd;
	ifb_half_t rd_mask;
	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Accepted accesses and the bits each bank may ever show
	assign acc_wr = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
	assign acc_rd = AVS_READ_IN && !AVS_WAITREQUEST_OUT;
	always_comb begin
		case (AVS_ADDRESS_IN)
			8'h00, 8'h0c: rd_mask = 16'h3fef;
			8'h04, 8'h10: rd_mask = 16'h20db;
			8'h08, 8'h14: rd_mask = 16'h0002;
			default: rd_mask = 16'hffff;
		endcase
	end
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (RST_IN);
	// ****************************************************************
	// Properties
	// ****************************************************************
	property p_wait_ans;
		(AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT;
	endproperty
	a_wait_ans: assert property (p_wait_ans) else $error("bus answer late");
	property p_wait_one;
		!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
	property p_rd_hi;
		AVS_READDATA_OUT[31:16] == 16'h0;
	endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("upper read half not zero");
	property p_rd_impl;
		acc_rd |-> (AVS_READDATA_OUT[15:0] & ~rd_mask) == 16'h0;
	endproperty
	a_rd_impl: assert property (p_rd_impl) else $error("absent bit reads one");
	property p_rd_unmapped;
		acc_rd && (AVS_ADDRESS_IN inside {[8'h1c:8'h2f], [8'h38:8'h3f]}) |-> AVS_READDATA_OUT == 32'h0;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
	// Requests only on implemented positions; a slip in a mask shows here
	property p_req_impl;
		(REQUEST0_OUT & ~16'h3fef) == 16'h0 && (REQUEST1_OUT & ~16'h20db) == 16'h0
			&& (REQUEST4_OUT & ~16'h0002) == 16'h0;
	endproperty
	a_req_impl: assert property (p_req_impl) else $error("request on absent bit");
	// Request bit 13 of bank 0 only rises two cycles after its event or an accepted write
	property p_req_cause;
		$rose(REQUEST0_OUT[13]) |-> $past(EVENT0_IN[13], 2) || $past(acc_wr, 2);
	endproperty
	a_req_cause: assert property (p_req_cause) else $error("request without cause");
	property p_reset_clear;
		$fell(RST_IN) |-> REQUEST0_OUT == 16'h0 && REQUEST1_OUT == 16'h0 && REQUEST4_OUT == 16'h0
			&& PRIO_LEVEL_OUT == 3'h0 && !IRQ_OUT && AVS_WAITREQUEST_OUT;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared by reset");
endmodule

bind ifb_top ifb_top_chk u_chk (.CLOCK_IN, .RST_IN, .AVS_ADDRESS_IN, .AVS_READ_IN, .AVS_WRITE_IN,
	.AVS_READDATA_OUT, .AVS_WAITREQUEST_OUT, .EVENT0_IN, .REQUEST0_OUT, .REQUEST1_OUT,
	.REQUEST4_OUT, .PRIO_LEVEL_OUT, .IRQ_OUT);

/* File: test/ifb_src_model.sv */
// Partner model: peripheral event sources and external pin drivers
module ifb_src_model (
	input wire logic clk_in,
	output ifb_pkg::ifb_half_t ev0_out,
	output ifb_pkg::ifb_half_t ev1_out,
	output ifb_pkg::ifb_half_t ev4_out,
	output logic [2:0] pin_out
);
	import ifb_pkg::*;
	// Quiet sources and low pins from time zero
	initial begin
		ev0_out = 16'h0;
		ev1_out = 16'h0;
		ev4_out = 16'h0;
		pin_out = 3'h0;
	end
	// One-cycle event pulse; bank 2 stands for flag bank 4
	task automatic pulse(input int bank, input int pos);
		@(posedge clk_in);
		case (bank)
			0: ev0_out[pos] <= 1'b1;
			1: ev1_out[pos] <= 1'b1;
			default: ev4_out[pos] <= 1'b1;
		endcase
		@(posedge clk_in);
		ev0_out <= 16'h0;
		ev1_out <= 16'h0;
		ev4_out <= 16'h0;
	endtask
	// Pin change, then hold long enough for the edge to reach the flag
	task automatic set_pin(input int idx, input logic lvl);
		@(posedge clk_in);
		pin_out[idx] <= lvl;
		repeat (3) @(posedge clk_in);
	endtask
endmodule

/* File: test/ifb_top_tb.sv */
// Testbench: register, event, pin and interrupt scenarios for the flag bank
module ifb_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ifb_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	ifb_addr_t adr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	ifb_word_t wdat = 32'h0;
	ifb_be_t be = 4'h0;
	ifb_word_t rdat;
	logic wait_q;
	ifb_half_t ev0, ev1, ev4, req0, req1, req4;
	logic [2:0] pins;
	ifb_prio_t prio;
	logic irq;
	ifb_word_t v;
	int mismatches = 0;
	int n_compared = 0;
	ifb_addr_t ofs[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
	ifb_half_t impl[6] = '{16'h3fef, 16'h20db, 16'h0002, 16'h3fef, 16'h20db, 16'h0002};
	ifb_half_t evm[3] = '{16'h3fee, 16'h00cb, 16'h0002};
	ifb_addr_t pofs[3] = '{8'h00, 8'h04, 8'h04};
	ifb_half_t pbit[3] = '{16'h0001, 16'h0010, 16'h2000};
	// 250 MHz system clock
	always #2 clk = ~clk;
	ifb_top DUT (.CLOCK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd),
		.AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat), .AVS_BYTEENABLE_IN(be),
		.AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wait_q), .EVENT0_IN(ev0),
		.EVENT1_IN(ev1), .EVENT4_IN(ev4), .EXT_PIN_IN(pins), .REQUEST0_OUT(req0),
		.REQUEST1_OUT(req1), .REQUEST4_OUT(req4), .PRIO_LEVEL_OUT(prio), .IRQ_OUT(irq));
	ifb_src_model u_src (.clk_in(clk), .ev0_out(ev0), .ev1_out(ev1), .ev4_out(ev4),
		.pin_out(pins));
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic check(input ifb_half_t seen, input ifb_half_t exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	// Request held until waitrequest is sampled low
	task automatic bus_wr(input ifb_addr_t a, input ifb_half_t d, input ifb_be_t b = 4'h3);
		@(posedge clk);
		adr <= a;
		wdat <= {16'h0, d};
		be <= b;
		wr <= 1'b1;
		do @(posedge clk); while (wait_q !== 1'b0);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input ifb_addr_t a, input ifb_half_t e, input string what);
		@(posedge clk);
		adr <= a;
		rd <= 1'b1;
		do @(posedge clk); while (wait_q !== 1'b0);
		v = rdat;
		rd <= 1'b0;
		check(v[15:0], e, what);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Watchdog: the whole sequence needs under a thousand cycles
	initial begin
		idle(20000);
		mismatches++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		give_verdict();
	end
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		idle(16);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			rd_chk(ofs[i], 16'h0, "reset value");
		end
		rd_chk(8'h40, 16'h4444, "priority reset");
		$display("test reset done");
		// All-ones writes expose exactly the implemented bits
		for (int i = 0; i < 6; i++) begin
			bus_wr(ofs[i], 16'hffff);
			rd_chk(ofs[i], impl[i], "ones");
			bus_wr(ofs[i], 16'h0);
			rd_chk(ofs[i], 16'h0, "zeros");
		end
		bus_wr(8'h0c, 16'hffff, 4'h1);
		rd_chk(8'h0c, 16'h00ef, "low lane");
		bus_wr(8'h0c, 16'h0);
		bus_wr(8'h20, 16'hffff);
		rd_chk(8'h20, 16'h0, "unmapped");
		$display("test registers done");
		// Every event bit with all enables off
		for (int g = 0; g < 3; g++) begin
			for (int p = 0; p < 16; p++) begin
				u_src.pulse(g, p);
				rd_chk(ofs[g], 16'(1 << p) & evm[g], "event");
				rd_chk(ofs[g], 16'(1 << p) & evm[g], "sticky");
				bus_wr(ofs[g], 16'h0);
			end
		end
		check(req0 | req1 | req4, 16'h0, "disabled request");
		$display("test events done");
		// Enable and priority gate the request
		bus_wr(8'h0c, 16'h2000);
		u_src.pulse(0, 13);
		u_src.pulse(0, 12);
		idle(3);
		check(req0, 16'h2000, "enabled request");
		check({13'h0, prio}, 16'h4, "level");
		bus_wr(8'h4c, 16'h0070);
		idle(3);
		check({13'h0, prio}, 16'h7, "level seven");
		bus_wr(8'h4c, 16'h0);
		idle(3);
		check(req0, 16'h0, "priority zero");
		bus_wr(8'h4c, 16'h0044);
		bus_wr(8'h00, 16'h0);
		$display("test request done");
		// Event on the very edge of a clearing write
		u_src.pulse(0, 11);
		fork
			bus_wr(8'h00, 16'h0);
			begin
				@(posedge clk);
				u_src.pulse(0, 11);
			end
		join
		rd_chk(8'h00, 16'h0800, "event beats clear");
		bus_wr(8'h00, 16'h0);
		$display("test clear race done");
		// Pin edges under both polarities
		for (int i = 0; i < 3; i++) begin
			u_src.set_pin(i, 1'b1);
			rd_chk(pofs[i], pbit[i], "rising");
			bus_wr(8'h18, 16'(1 << i));
			bus_wr(pofs[i], 16'h0);
			u_src.set_pin(i, 1'b0);
			rd_chk(pofs[i], pbit[i], "falling");
			bus_wr(pofs[i], 16'h0);
			u_src.set_pin(i, 1'b1);
			rd_chk(pofs[i], 16'h0, "rise ignored");
			bus_wr(8'h18, 16'h0);
			// Back to the idle low level so a later reset sees no false edge
			u_src.set_pin(i, 1'b0);
			bus_wr(pofs[i], 16'h0);
		end
		$display("test pins done");
		// Masked, then unmasked interrupt; status clears on read
		bus_wr(8'h0c, 16'h3000);
		u_src.pulse(0, 12);
		idle(3);
		check({15'h0, irq}, 16'h0, "masked irq");
		rd_chk(8'h30, 16'h0001, "status set");
		rd_chk(8'h30, 16'h0, "status cleared");
		bus_wr(8'h34, 16'h0001);
		u_src.pulse(0, 13);
		idle(3);
		check({15'h0, irq}, 16'h1, "irq raised");
		rd_chk(8'h30, 16'h0001, "status again");
		idle(2);
		check({15'h0, irq}, 16'h0, "irq dropped");
		$display("test interrupt done");
		// Second reset in mid-run
		rst <= 1'b1;
		idle(2);
		rst <= 1'b0;
		rd_chk(8'h00, 16'h0, "flags after reset");
		rd_chk(8'h0c, 16'h0, "enables after reset");
		check(req0, 16'h0, "request after reset");
		$display("test second reset done");
		give_verdict();
	end
endmodule
